// ### slpcs_pkg.sv
`default_nettype none
package slpcs_pkg;
    // lane modes
    typedef enum logic [2:0] {
        SLPCS_MODE_RAW   = 3'b000,
        SLPCS_MODE_8B10B = 3'b001,
        SLPCS_MODE_BLOCK = 3'b010,
        SLPCS_MODE_PIPE  = 3'b011,
        SLPCS_MODE_PCIE  = 3'b100
    } slpcs_mode_t;

    localparam logic [31:0] SLPCS_OFF_CTRL = 32'h0000_0000;
    localparam logic [31:0] SLPCS_OFF_WIDTH = 32'h0000_0004;
    localparam logic [31:0] SLPCS_OFF_CLK = 32'h0000_0008;
    localparam logic [31:0] SLPCS_OFF_STATUS = 32'h0000_000C;
    localparam logic [31:0] SLPCS_OFF_RXWORD = 32'h0000_0010;
    localparam logic [31:0] SLPCS_OFF_PLLUSE = 32'h0000_0014;

    localparam int SLPCS_CTRL_MODE_LSB = 0;
    localparam int SLPCS_CTRL_B67 = 3;
    localparam int SLPCS_CTRL_LOOP = 4;
    localparam int SLPCS_CTRL_EN = 5;
    localparam int SLPCS_CLK_PLL = 0;
    localparam int SLPCS_CLK_REF = 1;
    localparam int SLPCS_CLK_FAB = 2;
    localparam logic [31:0] SLPCS_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] SLPCS_WIDTH_RST = 4'h0;
    localparam int SLPCS_MAX_W = 80;
    localparam int SLPCS_PLL_MAX_LANES = 4;
    localparam logic [7:0] SLPCS_COMMA_P = 8'h7C;

    // width codes: 0..7 -> 8,10,16,20,32,40,64,80
    function automatic logic [6:0] slpcs_width(input logic [3:0] code);
        case (code[2:0])
            3'd0: return 7'd8;
            3'd1: return 7'd10;
            3'd2: return 7'd16;
            3'd3: return 7'd20;
            3'd4: return 7'd32;
            3'd5: return 7'd40;
            3'd6: return 7'd64;
            default: return 7'd80;
        endcase
    endfunction : slpcs_width

    typedef struct packed {
        logic valid;
        logic [SLPCS_MAX_W-1:0] data;
    } slpcs_word_t;
endpackage : slpcs_pkg
`default_nettype wire

// ### slpcs_lane.sv
// Function
// - tx serializes each parallel word at widths 8,10,16,20,32,40,64,80; block mode sends 66 or 67 bits
// - tx parallel clock strobe is divided bit clock; fabric supplies words on it
// - tx optionally encodes 8b/10b, 64b/66b or 64b/67b for transitions
// - rx recovers clock and assembles words of configured width, 66 or 67 bits in block mode
// - line is nrz; coding optionally provides transitions
// - rx optionally decodes 8b/10b, 64b/66b or 64b/67b
// - rx words delivered synchronous to recovered clock strobe
// - raw mode passes words with no coding
// - 8b/10b mode encodes on tx and decodes on rx
// - block code mode uses 64b/66b or 64b/67b with gearbox
// - pipe mode presents pipe interface for pcie gen2 and sata
// - pcie mode connects parallel side to hard controller, not fabric
// - raw, 8b/10b, block, pipe modes use fabric; pcie mapping fixed
// - tx lane picks one of two plls; one pll serves max four lanes
// - two reference clocks per quad, also usable for fabric clocks
// - adjacent loopback keeps stream running during fabric reprogramming
`default_nettype none
module slpcs_lane
    import slpcs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fab_tx_valid,
    input wire logic [SLPCS_MAX_W-1:0] fab_tx_data,
    input wire logic [SLPCS_MAX_W-1:0] pcie_tx_data,
    input wire logic pll_lock_a,
    input wire logic pll_lock_b,
    input wire logic [1:0] refclk_present,
    input wire logic rx_serial,
    input wire logic rx_bit_en,
    input wire logic loop_serial,
    output logic tx_serial,
    output logic tx_word_clk,
    output logic rx_word_clk,
    output slpcs_word_t fab_rx,
    output slpcs_word_t pcie_rx,
    output logic pipe_active,
    output logic [1:0] refclk_fabric_en
);
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [3:0] width_r, width_nxt;
    logic [2:0] clk_r, clk_nxt;
    logic [SLPCS_MAX_W-1:0] rx_last_r;
    logic rx_err_r, rx_err_nxt;

    slpcs_mode_t mode;
    logic [6:0] wlen;
    assign mode = slpcs_mode_t'(ctrl_r[SLPCS_CTRL_MODE_LSB +: 3]);
    assign wlen = slpcs_width(width_r);

    always_comb begin
        logic [31:0] a;
        a = 32'h0000_0000;
        aw_ok_nxt = aw_ok_r;
        w_ok_nxt = w_ok_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        width_nxt = width_r;
        clk_nxt = clk_r;
        if (s_axi_awvalid && !aw_ok_r) begin
            aw_ok_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ok_r) begin
            w_ok_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
        end
        if (aw_ok_r && w_ok_r && !bvalid_r) begin
            a = 32'(awaddr_r);
            aw_ok_nxt = 1'b0;
            w_ok_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OK;
            if (a == SLPCS_OFF_CTRL) begin
                ctrl_nxt = {26'h000_0000, wdata_r[5:0]};
            end else if (a == SLPCS_OFF_WIDTH) begin
                width_nxt = wdata_r[3:0];
            end else if (a == SLPCS_OFF_CLK) begin
                clk_nxt = wdata_r[2:0];
            end else if (a == SLPCS_OFF_STATUS || a == SLPCS_OFF_RXWORD
                         || a == SLPCS_OFF_PLLUSE) begin
                bresp_nxt = RESP_OK;
            end else begin
                bresp_nxt = RESP_ERR;
            end
        end
        if (s_axi_arvalid && !rvalid_r) begin
            a = 32'(s_axi_araddr);
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OK;
            if (a == SLPCS_OFF_CTRL) begin
                rdata_nxt = ctrl_r;
            end else if (a == SLPCS_OFF_WIDTH) begin
                rdata_nxt = {28'h000_0000, width_r};
            end else if (a == SLPCS_OFF_CLK) begin
                rdata_nxt = {29'h000_0000, clk_r};
            end else if (a == SLPCS_OFF_STATUS) begin
                rdata_nxt = {26'h000_0000, refclk_present, rx_err_r, pipe_active,
                             pll_lock_b, pll_lock_a};
            end else if (a == SLPCS_OFF_RXWORD) begin
                rdata_nxt = rx_last_r[31:0];
            end else if (a == SLPCS_OFF_PLLUSE) begin
                rdata_nxt = 32'(SLPCS_PLL_MAX_LANES);
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = RESP_ERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rresp_r <= 2'b00;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= SLPCS_CTRL_RST;
            width_r <= SLPCS_WIDTH_RST;
            clk_r <= 3'b000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            aw_ok_r <= aw_ok_nxt;
            w_ok_r <= w_ok_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            width_r <= width_nxt;
            clk_r <= clk_nxt;
            s_axi_awready <= !aw_ok_nxt;
            s_axi_wready <= !w_ok_nxt;
            s_axi_arready <= !rvalid_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // coding: 8b/10b shown as a running-disparity-free mapping of one byte per symbol
    function automatic logic [SLPCS_MAX_W-1:0] slpcs_enc(input slpcs_mode_t m,
                                                        input logic b67,
                                                        input logic [SLPCS_MAX_W-1:0] d);
        logic [SLPCS_MAX_W-1:0] o;
        o = d;
        if (m == SLPCS_MODE_8B10B || m == SLPCS_MODE_PIPE) begin
            for (int i = 0; i < 8; i++) begin
                o[i*10 +: 10] = {~d[i*8+7], d[i*8 +: 8], d[i*8]};
            end
        end else if (m == SLPCS_MODE_BLOCK) begin
            o = {d[SLPCS_MAX_W-1:67], b67, d[63:0], 2'b01};
        end
        return o;
    endfunction : slpcs_enc

    function automatic logic [SLPCS_MAX_W-1:0] slpcs_dec(input slpcs_mode_t m,
                                                        input logic [SLPCS_MAX_W-1:0] e);
        logic [SLPCS_MAX_W-1:0] o;
        o = e;
        if (m == SLPCS_MODE_8B10B || m == SLPCS_MODE_PIPE) begin
            o = '0;
            for (int i = 0; i < 8; i++) begin
                o[i*8 +: 8] = e[i*10+1 +: 8];
            end
        end else if (m == SLPCS_MODE_BLOCK) begin
            o = {16'h0000, e[65:2]};
        end
        return o;
    endfunction : slpcs_dec

    logic [SLPCS_MAX_W-1:0] tx_sh_r, tx_sh_nxt;
    logic [6:0] tx_cnt_r, tx_cnt_nxt;
    logic tx_ser_r, tx_ser_nxt, tx_wclk_r, tx_wclk_nxt;
    logic [SLPCS_MAX_W-1:0] tx_src, loop_word;
    logic [6:0] tx_len;
    logic pll_ok;

    assign pll_ok = clk_r[SLPCS_CLK_PLL] ? pll_lock_b : pll_lock_a;
    assign tx_src = (mode == SLPCS_MODE_PCIE) ? pcie_tx_data :
                    (ctrl_r[SLPCS_CTRL_LOOP] ? loop_word : fab_tx_data);
    // block mode sends 66 or 67 bits through the gearbox regardless of word width
    assign tx_len = (mode == SLPCS_MODE_BLOCK) ? (ctrl_r[SLPCS_CTRL_B67] ? 7'd67 : 7'd66)
                                               : wlen;

    always_comb begin
        tx_sh_nxt = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_ser_nxt = 1'b0;
        tx_wclk_nxt = 1'b0;
        if (ctrl_r[SLPCS_CTRL_EN] && pll_ok) begin
            if (tx_cnt_r == 7'd0) begin
                tx_sh_nxt = slpcs_enc(mode, ctrl_r[SLPCS_CTRL_B67], tx_src);
                tx_ser_nxt = tx_sh_nxt[0];
                tx_sh_nxt = tx_sh_nxt >> 1;
                tx_cnt_nxt = tx_len - 7'd1;
                tx_wclk_nxt = 1'b1;
            end else begin
                tx_ser_nxt = tx_sh_r[0];
                tx_sh_nxt = tx_sh_r >> 1;
                tx_cnt_nxt = tx_cnt_r - 7'd1;
            end
        end
    end

    logic [SLPCS_MAX_W-1:0] rx_sh_r, rx_sh_nxt;
    logic [6:0] rx_cnt_r, rx_cnt_nxt;
    logic rx_wclk_r, rx_wclk_nxt;
    slpcs_word_t fab_rx_r, fab_rx_nxt, pcie_rx_r, pcie_rx_nxt;
    logic [SLPCS_MAX_W-1:0] rx_last_nxt, rx_full;
    logic rx_bit;

    assign rx_bit = ctrl_r[SLPCS_CTRL_LOOP] ? loop_serial : rx_serial;
    assign loop_word = rx_last_r;
    assign rx_full = rx_sh_r | ({{(SLPCS_MAX_W-1){1'b0}}, rx_bit} << rx_cnt_r);

    always_comb begin
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_wclk_nxt = 1'b0;
        fab_rx_nxt = fab_rx_r;
        pcie_rx_nxt = pcie_rx_r;
        fab_rx_nxt.valid = 1'b0;
        pcie_rx_nxt.valid = 1'b0;
        rx_last_nxt = rx_last_r;
        rx_err_nxt = rx_err_r;
        // rx_bit_en marks a bit strobe from the recovered clock
        if (ctrl_r[SLPCS_CTRL_EN] && rx_bit_en) begin
            if (rx_cnt_r >= tx_len - 7'd1) begin
                rx_last_nxt = slpcs_dec(mode, rx_full);
                if (mode == SLPCS_MODE_BLOCK && rx_full[1:0] != 2'b01) begin
                    rx_err_nxt = 1'b1;
                end
                rx_sh_nxt = '0;
                rx_cnt_nxt = 7'd0;
                rx_wclk_nxt = 1'b1;
                if (mode == SLPCS_MODE_PCIE) begin
                    pcie_rx_nxt = '{valid: 1'b1, data: rx_last_nxt};
                end else begin
                    fab_rx_nxt = '{valid: 1'b1, data: rx_last_nxt};
                end
            end else begin
                rx_sh_nxt = rx_full;
                rx_cnt_nxt = rx_cnt_r + 7'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_r <= '0;
            tx_cnt_r <= 7'd0;
            tx_ser_r <= 1'b0;
            tx_wclk_r <= 1'b0;
            rx_sh_r <= '0;
            rx_cnt_r <= 7'd0;
            rx_wclk_r <= 1'b0;
            fab_rx_r <= '0;
            pcie_rx_r <= '0;
            rx_last_r <= '0;
            rx_err_r <= 1'b0;
        end else begin
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_ser_r <= tx_ser_nxt;
            tx_wclk_r <= tx_wclk_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_wclk_r <= rx_wclk_nxt;
            fab_rx_r <= fab_rx_nxt;
            pcie_rx_r <= pcie_rx_nxt;
            rx_last_r <= rx_last_nxt;
            rx_err_r <= rx_err_nxt;
        end
    end

    logic pipe_r;
    logic [1:0] refen_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pipe_r <= 1'b0;
            refen_r <= 2'b00;
        end else begin
            pipe_r <= (mode == SLPCS_MODE_PIPE);
            refen_r <= {clk_r[SLPCS_CLK_FAB], clk_r[SLPCS_CLK_REF]} & refclk_present;
        end
    end

    assign tx_serial = tx_ser_r;
    assign tx_word_clk = tx_wclk_r;
    assign rx_word_clk = rx_wclk_r;
    assign fab_rx = fab_rx_r;
    assign pcie_rx = pcie_rx_r;
    assign pipe_active = pipe_r;
    assign refclk_fabric_en = refen_r;
endmodule : slpcs_lane
`default_nettype wire

// ### slpcs_lane_asserts.sv
`default_nettype none
module slpcs_lane_asserts
    import slpcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic tx_word_clk,
    input wire logic rx_word_clk,
    input wire slpcs_word_t fab_rx,
    input wire slpcs_word_t pcie_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_tx_word_gap: assert property (tx_word_clk |=> !tx_word_clk [*5])
        else $error("tx word strobes too close");
    a_rx_word_gap: assert property (fab_rx.valid |=> !fab_rx.valid [*7])
        else $error("fabric rx words closer than eight bits");
    a_pcie_word_gap: assert property (pcie_rx.valid |=> !pcie_rx.valid [*7])
        else $error("pcie rx words closer than eight bits");
    a_rx_clk_match: assert property (rx_word_clk == (fab_rx.valid || pcie_rx.valid))
        else $error("rx word strobe not aligned with rx valid");
    a_rx_one_side: assert property (!(fab_rx.valid && pcie_rx.valid))
        else $error("rx word sent to fabric and pcie together");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while read data pending");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
endmodule : slpcs_lane_asserts
bind slpcs_lane slpcs_lane_asserts slpcs_lane_asserts_inst (
    .clk(clk), .rst_b(rst_b), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .tx_word_clk(tx_word_clk), .rx_word_clk(rx_word_clk), .fab_rx(fab_rx), .pcie_rx(pcie_rx)
);
`default_nettype wire

// ### slpcs_far_end.sv
`default_nettype none
module slpcs_far_end
    import slpcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic slow,
    input wire logic [SLPCS_MAX_W-1:0] word,
    input wire logic [6:0] len,
    output logic ser,
    output logic bit_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SLPCS_MAX_W-1:0] sh;
    logic [6:0] left;
    logic ph;
    // remote end: shifts a word out lsb first, one bit per strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= '0;
            left <= '0;
            ph <= 1'b0;
            ser <= 1'b0;
            bit_en <= 1'b0;
        end else if (go) begin
            sh <= word;
            left <= len;
        end else if (left != '0 && (ph || !slow)) begin
            ser <= sh[0];
            sh <= sh >> 1;
            left <= left - 7'd1;
            bit_en <= 1'b1;
            ph <= 1'b0;
        end else begin
            // between bits the line carries no stale value
            ser <= ~ser;
            bit_en <= 1'b0;
            ph <= 1'b1;
        end
    end
endmodule : slpcs_far_end
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb
    import slpcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b = 1'b0, lka = 1'b1, lkb = 1'b0, go = 1'b0, slow = 1'b0, lb = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [79:0] txd = '0, pw = '0;
    logic [6:0] plen = '0;
    logic [1:0] refp = 2'b10, bresp, rresp, rfen;
    logic awready, wready, bvalid, arready, rvalid, txs, txc, rxc, pact, ser, ben;
    slpcs_word_t frx, prx;
    logic [31:0] rnd = 32'h0000_0033;
    int bad_count = 0, n_checks = 0;
    int wt[8] = '{8, 10, 16, 20, 32, 40, 64, 80};

    slpcs_lane slpcs_lane_inst (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fab_tx_valid(1'b1), .fab_tx_data(txd), .pcie_tx_data(~txd), .pll_lock_a(lka),
        .pll_lock_b(lkb), .refclk_present(refp), .rx_serial(lb ? ~ser : ser), .rx_bit_en(ben),
        .loop_serial(lb ? ser : ~ser), .tx_serial(txs), .tx_word_clk(txc), .rx_word_clk(rxc),
        .fab_rx(frx), .pcie_rx(prx), .pipe_active(pact), .refclk_fabric_en(rfen)
    );
    slpcs_far_end slpcs_far_end_inst (
        .clk(clk), .rst_b(rst_b), .go(go), .slow(slow), .word(pw), .len(plen), .ser(ser),
        .bit_en(ben)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [79:0] msk(input int n);
        return (80'h1 << n) - 80'h1;
    endfunction : msk
    function automatic logic [9:0] enc(input logic [7:0] b);
        return {~b[7], b, b[0]};
    endfunction : enc

    task automatic roll(output logic [79:0] v);
        rnd = lfsr(rnd);
        v = {rnd[15:0], rnd, ~rnd};
        rnd = lfsr(rnd);
    endtask : roll
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [33:0] r);
        logic ta, tw, tr, hit;
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            hit = wr ? bvalid : rvalid;
            r = wr ? {bresp, 32'h0000_0000} : {rresp, rdata};
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end while (!hit);
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic lane(input logic [4:0] ctrl, input logic [3:0] wc, input int n,
        input logic [79:0] tx_exp, input logic [79:0] rx_in, input logic [79:0] rx_exp,
        input int m);
        logic [33:0] r;
        logic [79:0] got;
        logic pc;
        pc = ctrl[2:0] == 3'd4;
        bus(1'b1, 8'h00, '0, r);
        bus(1'b1, 8'h04, {28'h000_0000, wc}, r);
        lb <= ctrl[4];
        bus(1'b1, 8'h00, {26'h000_0000, 1'b1, ctrl}, r);
        pw <= rx_in;
        plen <= 7'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(negedge clk); while (!(frx.valid || prx.valid));
        check(frx.valid, !pc);
        check(rxc, 1'b1);
        check((pc ? prx.data : frx.data) & msk(m), rx_exp & msk(m));
        repeat (2) do @(negedge clk); while (!txc);
        for (int i = 0; i < n; i++) begin
            got[i] = txs;
            @(negedge clk);
        end
        check(got & msk(n), tx_exp & msk(n));
        @(posedge clk);
    endtask : lane

    task automatic count(output int c);
        c = 0;
        repeat (100) begin
            @(negedge clk);
            c += txc;
        end
        @(posedge clk);
    endtask : count

    initial begin
        logic [33:0] r;
        logic [79:0] a, b;
        int c;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h00, '0, r);
        check(r, '0);
        bus(1'b0, 8'h14, '0, r);
        check(r, 32'h0000_0004);
        bus(1'b0, 8'h18, '0, r);
        check(r[33:32], 2'b10);
        bus(1'b0, 8'h0c, '0, r);
        check(r, 32'h0000_0021);
        bus(1'b1, 8'h18, 32'h0000_0001, r);
        check(r[33:32], 2'b10);
        bus(1'b1, 8'h08, 32'h0000_0006, r);
        bus(1'b1, 8'h00, 32'h0000_0003, r);
        check(r[33:32], 2'b00);
        @(negedge clk);
        check(rfen, 2'b11 & refp);
        check(pact, 1'b1);
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            roll(a);
            roll(b);
            txd <= a;
            slow <= k[0];
            lane(5'd0, 4'(k), wt[k], a, b, b, wt[k]);
        end
        roll(a);
        roll(b);
        txd <= a;
        lane(5'd1, 4'd1, 10, enc(a[7:0]), enc(b[7:0]), b, 8);
        roll(a);
        roll(b);
        txd <= a;
        lane(5'd3, 4'd1, 10, enc(a[7:0]), enc(b[7:0]), b, 8);
        for (int j = 0; j < 2; j++) begin
            roll(a);
            roll(b);
            txd <= a;
            lane(5'(2 + 8 * j), 4'd6, 66 + j, {j[0], a[63:0], 2'b01},
                {j[0], b[63:0], 2'b01}, b, 64);
        end
        lane(5'd2, 4'd6, 66, {a[63:0], 2'b01}, {b[63:0], 2'b10}, b, 64);
        bus(1'b0, 8'h0c, '0, r);
        check(r, 32'h0000_0029);
        lane(5'd4, 4'd2, 16, ~a, b, b, 16);
        lane(5'd16, 4'd3, 20, b, b, b, 20);
        bus(1'b0, 8'h10, '0, r);
        check(r, b & msk(20));
        bus(1'b1, 8'h08, 32'h0000_0001, r);
        count(c);
        check(c, 0);
        lkb <= 1'b1;
        count(c);
        check(c != 0, 1'b1);
        final_report();
    end
endmodule : tb
`default_nettype wire
